// file: dv/acsc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Converter cores and trigger pin, as the device sees them
// ------------------------------------------------------------
module acsc_core_model #(
   parameter logic [11:0] BASE = 12'hA00
) (
   input  wire logic             core_clk,
   input  wire logic             pulse_req,
   output logic      [5:0][11:0] core_data,
   output logic                  external_cal_trigger_pin
);
   logic [3:0] hold_ff = 4'h0;

   // Distinct nonzero code per core: a wrong route or a gap shows at once
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         core_data[i] = BASE + 12'(i);
      end
   end

   // Pin held several cycles, the synchroniser needs agreeing stages
   always_ff @(posedge core_clk) begin
      if (pulse_req) begin
         hold_ff <= 4'h8;
      end else if (hold_ff != 4'h0) begin
         hold_ff <= hold_ff - 4'h1;
      end
   end
   assign external_cal_trigger_pin = (hold_ff != 4'h0);
endmodule : acsc_core_model
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [7:0]  PL = 8'h02;
   localparam logic [11:0] CB = 12'hA00;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} acsc_row_t;
   logic                   core_clk  = 1'b0;
   logic                   rst_n     = 1'b0;
   logic [7:0]             reg_addr  = 8'h00;
   logic [7:0]             reg_wdata = 8'h00;
   logic                   reg_wr    = 1'b0;
   logic                   reg_rd    = 1'b0;
   logic                   pulse_req = 1'b0;
   logic                   bg_on     = 1'b0;
   logic [15:0][7:0]       factory_trim;
   logic [7:0]             rv;
   wire logic [7:0]        reg_rdata;
   wire logic              pin;
   wire logic [5:0][11:0]  core_data;
   wire logic [3:0][11:0]  ch_data;
   wire logic [5:0]        core_offline;
   wire logic [5:0]        core_cal;
   wire logic [1:0]        cal_phase;
   wire logic [15:0][7:0]  trim_value;
   wire logic              fg_done;
   wire logic [1:0][3:0][11:0] v_ch;
   wire logic [1:0][5:0]   v_off;
   int                     fails = 0;
   int                     n_compared = 0;
   // Address, write data, write flag, expected read-back
   acsc_row_t rows [8] = '{'{8'h9A, 8'h00, 1'b0, 8'h00}, '{8'h9B, 8'h00, 1'b0, 8'h00},
      '{8'hA3, 8'h00, 1'b0, 8'h33}, '{8'h9A, 8'h1F, 1'b1, 8'h1F}, '{8'h9B, 8'h1E, 1'b1, 8'h1E},
      '{8'hA0, 8'h5A, 1'b1, 8'h5A}, '{8'hAF, 8'hC3, 1'b1, 8'hC3}, '{8'h90, 8'h77, 1'b1, 8'h00}};

   // ------------------------------------------------------------
   // Design instances and far side
   // ------------------------------------------------------------
   acsc_ctrl #(.NUM_CH(4), .PHASE_LEN(PL)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_cal_trigger_pin(pin),
      .factory_trim(factory_trim), .core_data(core_data), .ch_data(ch_data),
      .core_offline(core_offline), .core_cal(core_cal), .cal_phase(cal_phase),
      .trim_value(trim_value), .fg_done(fg_done));
   // Single and dual channel variants share the bus and the cores
   for (genvar g = 0; g < 2; g++) begin : g_var
      acsc_ctrl #(.NUM_CH(g + 1), .PHASE_LEN(PL)) dut_var (
         .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
         .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .external_cal_trigger_pin(pin),
         .factory_trim(factory_trim), .core_data(core_data), .ch_data(v_ch[g]),
         .core_offline(v_off[g]), .core_cal(), .cal_phase(), .trim_value(), .fg_done());
   end
   acsc_core_model #(.BASE(CB)) cores (
      .core_clk(core_clk), .pulse_req(pulse_req), .core_data(core_data),
      .external_cal_trigger_pin(pin));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic wait_fg(input logic v, input int n);
      for (int i = 0; i < n && fg_done !== v; i++) @(negedge core_clk);
      chk(12'(fg_done), 12'(v));
   endtask : wait_fg
   task automatic wait_ch(input int k, input logic [11:0] v);
      for (int i = 0; i < 400 && ch_data[k] !== v; i++) @(negedge core_clk);
      chk(ch_data[k], v);
   endtask : wait_ch
   task automatic end_sim;
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------
   // Clock, monitors, watchdog
   // ------------------------------------------------------------
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Per-cycle checks; a gap in background mode would show as a zero
   always @(negedge core_clk) begin
      if (rst_n) begin
         chk(12'($countones(core_cal) <= 1), 12'h001);
         chk(12'(cal_phase != 2'h3), 12'h001);
      end
      if (bg_on) begin
         chk(12'(ch_data[0] != 0 && ch_data[1] != 0 && ch_data[2] != 0 && ch_data[3] != 0), 12'h001);
      end
   end
   // Whole run is well under two thousand cycles
   initial begin
      #(25 * 4000);
      fails++;
      end_sim();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      for (int i = 0; i < 16; i++) factory_trim[i] = 8'h30 + 8'(i);
      repeat (11) @(posedge core_clk);
      @(negedge core_clk);
      chk(12'(core_offline), 12'h03F);
      chk(12'(core_cal), 12'h001);
      chk(12'(fg_done), 12'h000);
      @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 chk(12'(trim_value[3]), 12'h033);
      repeat (10) @(negedge core_clk);
      chk(ch_data[0] | ch_data[1] | ch_data[2] | ch_data[3], 12'h000);
      chk(12'(core_offline), 12'h03F);
      chk(12'(core_cal), 12'h002);
      // Three phases of three cycles per core: core 4 is now in its gain step
      repeat (29) @(negedge core_clk);
      chk(12'(core_cal), 12'h010);
      chk(12'(cal_phase), 12'h001);
      chk(12'(fg_done), 12'h000);
      wait_fg(1'b1, 100);
      repeat (2) @(negedge core_clk);
      chk(ch_data[0], CB + 12'h0);
      chk(ch_data[1], CB + 12'h1);
      chk(ch_data[2], CB + 12'h4);
      chk(ch_data[3], CB + 12'h5);
      // Register table: reset values, read-back, unmapped place
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rv);
         chk(12'(rv), 12'(rows[i].e));
      end
      chk(12'(trim_value[0]), 12'h05A);
      chk(12'(trim_value[15]), 12'h0C3);
      rd(8'h81, rv);
      chk(12'(rv[0]), 12'h001);
      // Pin as trigger source, then software bit ignored under it
      wr(8'h80, 8'h02);
      @(posedge core_clk);
      pulse_req <= 1'b1;
      @(posedge core_clk);
      pulse_req <= 1'b0;
      wait_fg(1'b0, 12);
      repeat (2) @(negedge core_clk);
      chk(ch_data[0] | ch_data[1] | ch_data[2] | ch_data[3], 12'h000);
      wait_fg(1'b1, 100);
      wr(8'h80, 8'h06);
      repeat (12) @(negedge core_clk);
      chk(12'(fg_done), 12'h001);
      // Background: enable, software source, soft trigger
      wr(8'h80, 8'h00);
      wr(8'h80, 8'h05);
      wait_fg(1'b0, 12);
      wait_fg(1'b1, 100);
      bg_on = 1'b1;
      wait_ch(0, CB + 12'h2);
      chk(v_ch[0][0], CB + 12'h2);
      chk(v_ch[1][0], CB + 12'h2);
      wait_ch(1, CB + 12'h0);
      chk(v_ch[1][1], CB + 12'h0);
      chk(v_ch[0][0], CB + 12'h0);
      wait_ch(2, CB + 12'h3);
      chk(12'(v_off[1][3]), 12'h001);
      chk(v_ch[0][1], 12'h000);
      // Status one cycle into the next pass: background busy, core 4 calibrating
      rd(8'h81, rv);
      chk(12'(rv), 12'h025);
      // Reset in mid-run: background stops, foreground pass runs again
      @(posedge core_clk);
      bg_on = 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk(12'(core_offline), 12'h03F);
      chk(12'(core_cal), 12'h001);
      chk(12'(fg_done), 12'h000);
      chk(12'(trim_value[0]), 12'h000);
      rd(8'h9A, rv);
      chk(12'(rv), 12'h000);
      chk(12'(trim_value[0]), 12'h030);
      wait_fg(1'b1, 100);
      repeat (2) @(negedge core_clk);
      chk(ch_data[0], CB + 12'h0);
      chk(ch_data[2], CB + 12'h4);
      end_sim();
   end
endmodule : testbench
`default_nettype wire

// file: verilog/acsc_ctrl.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RL1] Foreground calibration takes cores offline and forces all outputs to zero.
// [RL2] Six cores; foreground map A=0, B=1, C=4, D=5.
// [RL3] Four-channel: spare 2 rotates with cores 0/1, spare 3 with 4/5.
// [RL4] Two-channel: cores 0 and 1 share spare core 2 only.
// [RL5] Single-channel: core 0 rotates with spare core 2.
// [RL6] Foreground calibration runs after reset; host waits before programming.
// [RL7] Trigger source select picks pin or software bit to start foreground.
// [RL8] Host enables background: enable bit, select 0, software trigger 1.
// [RL9] Spare takes over before displaced core goes offline; output never gaps.
// [RL10] Displaced core is calibrated, then replaces the next core, forever.
// [RL11] Never more than one core calibrating at once.
// [RL12] Each pass steps linearity, gain, then offset against internal reference.
// [RL13] Host should program source delay 0x1F and mux delay 0x1E.
// [RL14] Trims writable, factory values loaded at start-up.
// [RL15] Trim values read back from trim registers.
// [RL16] Trims held per core and per input.
// [RL17] Status shows foreground calibration done.
module acsc_ctrl #(
   parameter int         NUM_CH    = 4,
   parameter logic [7:0] PHASE_LEN = acsc_pkg::PHASE_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              external_cal_trigger_pin,
   input  wire logic [15:0][7:0]  factory_trim,
   input  wire logic [5:0][11:0]  core_data,
   output logic      [3:0][11:0]  ch_data,
   output logic      [5:0]        core_offline,
   output logic      [5:0]        core_cal,
   output logic      [1:0]        cal_phase,
   output logic      [15:0][7:0]  trim_value,
   output logic                   fg_done
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      acsc_pkg::acsc_state_t st;
      logic [2:0]            pin_sync;
      logic                  pin_lvl;
      logic                  trig_prev;
      logic                  bg_en;
      logic                  src_sel;
      logic                  sw_trig;
      logic [7:0]            src_dly;
      logic [7:0]            mux_dly;
      logic [15:0][7:0]      trim;
      logic                  trim_loaded;
      logic [2:0]            cal_idx;
      logic [1:0]            phase;
      logic [7:0]            cnt;
      logic [1:0]            ptr;
      logic [3:0][2:0]       serve;
      logic [1:0][2:0]       spare;
      logic                  fg_done;
      logic [3:0][11:0]      ch_data;
      logic [5:0]            offline;
      logic [5:0]            cal_mask;
      logic [7:0]            rdata;
   } acsc_reg_t;

   acsc_reg_t r_ff;
   acsc_reg_t nxt_r;

   // Foreground core-to-input assignment
   function automatic logic [3:0][2:0] home_map();
      home_map = {acsc_pkg::CORE_D, acsc_pkg::CORE_C, acsc_pkg::CORE_B, acsc_pkg::CORE_A}; // RL2
   endfunction : home_map

   // Group of a channel: A/B share spare 0, C/D share spare 1
   function automatic logic chan_group(input logic [1:0] ch);
      chan_group = ch[1]; // RL3 RL4 RL5
   endfunction : chan_group

   logic        trig_lvl;
   logic        trig_rise;
   logic        phase_end;
   logic        grp;

   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   assign trig_lvl  = r_ff.src_sel ? r_ff.pin_lvl : r_ff.sw_trig; // RL7
   assign trig_rise = trig_lvl & ~r_ff.trig_prev;
   assign phase_end = (r_ff.cnt == 8'h00);
   assign grp       = chan_group(r_ff.ptr);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      // Pin passes three flops; level only moves when stages 2 and 3 agree
      nxt_r.pin_sync = {r_ff.pin_sync[1:0], external_cal_trigger_pin};
      if (r_ff.pin_sync[2] == r_ff.pin_sync[1]) begin
         nxt_r.pin_lvl = r_ff.pin_sync[2];
      end
      nxt_r.trig_prev = trig_lvl;
      nxt_r.rdata     = 8'h00;

      // Factory trims load once, the first cycle after reset release
      if (!r_ff.trim_loaded) begin
         nxt_r.trim        = factory_trim; // RL14
         nxt_r.trim_loaded = 1'b1;
      end else if (reg_wr && reg_addr >= acsc_pkg::ADDR_TRIM_LO && reg_addr <= acsc_pkg::ADDR_TRIM_HI) begin
         nxt_r.trim[reg_addr[3:0]] = reg_wdata; // RL14 RL16
      end

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            acsc_pkg::ADDR_CTRL: begin
               nxt_r.bg_en   = reg_wdata[acsc_pkg::CTRL_BG_EN_BIT];
               nxt_r.src_sel = reg_wdata[acsc_pkg::CTRL_SRC_SEL_BIT];
               nxt_r.sw_trig = reg_wdata[acsc_pkg::CTRL_SW_TRIG_BIT];
            end
            acsc_pkg::ADDR_SRC_DLY: nxt_r.src_dly = reg_wdata;
            acsc_pkg::ADDR_MUX_DLY: nxt_r.mux_dly = reg_wdata;
            default: ;
         endcase
      end

      // Register reads, data valid the following cycle only
      if (reg_rd) begin
         if (reg_addr == acsc_pkg::ADDR_CTRL) begin
            nxt_r.rdata = {5'h00, r_ff.sw_trig, r_ff.src_sel, r_ff.bg_en};
         end else if (reg_addr == acsc_pkg::ADDR_STATUS) begin
            nxt_r.rdata = {2'h0, r_ff.cal_idx, (r_ff.st != acsc_pkg::ST_FG && r_ff.st != acsc_pkg::ST_IDLE),
                           (r_ff.st == acsc_pkg::ST_FG), r_ff.fg_done}; // RL17
         end else if (reg_addr == acsc_pkg::ADDR_SRC_DLY) begin
            nxt_r.rdata = r_ff.src_dly;
         end else if (reg_addr == acsc_pkg::ADDR_MUX_DLY) begin
            nxt_r.rdata = r_ff.mux_dly;
         end else if (reg_addr >= acsc_pkg::ADDR_TRIM_LO && reg_addr <= acsc_pkg::ADDR_TRIM_HI) begin
            nxt_r.rdata = r_ff.trim[reg_addr[3:0]]; // RL15
         end
      end

      // Calibration phase timer: linearity, gain, offset per core
      if (r_ff.st == acsc_pkg::ST_FG || r_ff.st == acsc_pkg::ST_BG_CAL) begin
         nxt_r.cnt = r_ff.cnt - 8'h01;
         if (phase_end) begin
            nxt_r.cnt   = PHASE_LEN;
            nxt_r.phase = r_ff.phase + 2'h1; // RL12
         end
      end

      // Sequencer; a trigger edge always restarts foreground
      unique case (r_ff.st)
         acsc_pkg::ST_FG: begin
            // All six cores calibrated one after another
            if (phase_end && r_ff.phase == acsc_pkg::LAST_PHASE) begin
               nxt_r.phase   = 2'h0;
               nxt_r.cal_idx = r_ff.cal_idx + 3'h1;
               if (r_ff.cal_idx == acsc_pkg::LAST_CORE) begin
                  nxt_r.st      = acsc_pkg::ST_IDLE;
                  nxt_r.cal_idx = 3'h0;
                  nxt_r.fg_done = 1'b1; // RL17
               end
            end
         end
         acsc_pkg::ST_IDLE: begin
            if (r_ff.bg_en) begin
               nxt_r.st      = acsc_pkg::ST_BG_CAL;
               nxt_r.cal_idx = r_ff.spare[grp]; // RL10
            end
         end
         acsc_pkg::ST_BG_CAL: begin
            if (!r_ff.bg_en) begin
               nxt_r.st    = acsc_pkg::ST_IDLE;
               nxt_r.phase = 2'h0;
               nxt_r.cnt   = PHASE_LEN;
            end else if (phase_end && r_ff.phase == acsc_pkg::LAST_PHASE) begin
               nxt_r.st    = acsc_pkg::ST_SWAP_SRC;
               nxt_r.phase = 2'h0;
               nxt_r.cnt   = r_ff.src_dly;
            end
         end
         acsc_pkg::ST_SWAP_SRC: begin
            // Spare input switch settles before the output mux moves
            nxt_r.cnt = r_ff.cnt - 8'h01;
            if (phase_end) begin
               nxt_r.st  = acsc_pkg::ST_SWAP_MUX;
               nxt_r.cnt = r_ff.mux_dly;
            end
         end
         acsc_pkg::ST_SWAP_MUX: begin
            nxt_r.cnt = r_ff.cnt - 8'h01;
            if (phase_end) begin
               nxt_r.serve[r_ff.ptr] = r_ff.spare[grp]; // RL9
               nxt_r.spare[grp]      = r_ff.serve[r_ff.ptr]; // RL10
               nxt_r.ptr             = (r_ff.ptr == 2'(NUM_CH - 1)) ? 2'h0 : r_ff.ptr + 2'h1;
               nxt_r.st              = acsc_pkg::ST_IDLE;
               nxt_r.cnt             = PHASE_LEN;
            end
         end
      endcase

      if (trig_rise) begin
         nxt_r.st      = acsc_pkg::ST_FG; // RL7
         nxt_r.fg_done = 1'b0;
         nxt_r.cal_idx = 3'h0;
         nxt_r.phase   = 2'h0;
         nxt_r.cnt     = PHASE_LEN;
         nxt_r.ptr     = 2'h0;
         nxt_r.serve   = home_map(); // RL2
         nxt_r.spare   = {acsc_pkg::SPARE_1, acsc_pkg::SPARE_0};
      end

      // Outputs registered from the next state
      nxt_r.cal_mask = 6'h00;
      if (nxt_r.st == acsc_pkg::ST_FG || nxt_r.st == acsc_pkg::ST_BG_CAL) begin
         nxt_r.cal_mask[nxt_r.cal_idx] = 1'b1; // RL11
      end
      nxt_r.offline = 6'h3F;
      for (int c = 0; c < 4; c++) begin
         nxt_r.ch_data[c] = 12'h000;
         if (c < NUM_CH && nxt_r.st != acsc_pkg::ST_FG) begin
            nxt_r.offline[nxt_r.serve[c]] = 1'b0;
            nxt_r.ch_data[c]              = core_data[nxt_r.serve[c]]; // RL9
         end
      end
      if (nxt_r.st == acsc_pkg::ST_SWAP_MUX || nxt_r.st == acsc_pkg::ST_SWAP_SRC) begin
         nxt_r.offline[nxt_r.spare[chan_group(nxt_r.ptr)]] = 1'b0; // RL9
      end
      if (nxt_r.st == acsc_pkg::ST_FG) begin
         nxt_r.offline = 6'h3F; // RL1
      end
   end

   // ----------------------------------------------------------------
   // Registers; reset starts the power-up foreground pass
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         r_ff             <= '0;
         r_ff.st          <= acsc_pkg::ST_FG; // RL6
         r_ff.cnt         <= PHASE_LEN;
         r_ff.serve       <= home_map();
         r_ff.spare       <= {acsc_pkg::SPARE_1, acsc_pkg::SPARE_0};
         r_ff.offline     <= 6'h3F;
         r_ff.cal_mask    <= 6'h01;
         r_ff.src_dly     <= acsc_pkg::SRC_DLY_RST;
         r_ff.mux_dly     <= acsc_pkg::MUX_DLY_RST;
         {r_ff.sw_trig, r_ff.src_sel, r_ff.bg_en} <= acsc_pkg::CTRL_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign reg_rdata    = r_ff.rdata;
   assign ch_data      = r_ff.ch_data;
   assign core_offline = r_ff.offline;
   assign core_cal     = r_ff.cal_mask;
   assign cal_phase    = r_ff.phase;
   assign trim_value   = r_ff.trim;
   assign fg_done      = r_ff.fg_done;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Outputs are registered from the next state, so they match the current state
   fg_mid_code_a: assert property ((r_ff.st == acsc_pkg::ST_FG) |-> (ch_data == '0 && core_offline == 6'h3F)) // RL1
      else $error("outputs not mid-code during foreground");
   one_cal_a: assert property ($onehot0(core_cal)) // RL11
      else $error("more than one core calibrating");
   spare_group_a: assert property ((r_ff.st == acsc_pkg::ST_BG_CAL && NUM_CH < 4) // RL4
      |-> r_ff.cal_idx inside {3'h0, 3'h1, 3'h2})
      else $error("wrong spare used on narrow variant");
   spare_map_a: assert property ((r_ff.st == acsc_pkg::ST_BG_CAL && r_ff.ptr[1]) // RL3
      |-> r_ff.cal_idx inside {3'h3, 3'h4, 3'h5})
      else $error("upper pair calibrated with wrong spare");
   single_pair_a: assert property ((NUM_CH == 1 && r_ff.st != acsc_pkg::ST_FG) // RL5
      |-> r_ff.serve[0] inside {3'h0, 3'h2})
      else $error("single channel left core 0/2 pair");
   // A trigger in the swap cycle restarts foreground and takes every core offline
   no_gap_a: assert property ((r_ff.st == acsc_pkg::ST_SWAP_MUX && phase_end && !trig_rise) // RL9
      |=> !core_offline[$past(r_ff.spare[grp])])
      else $error("new core offline after swap");
   rotate_a: assert property ((r_ff.st == acsc_pkg::ST_SWAP_MUX && phase_end && !trig_rise) // RL10
      |=> r_ff.spare[$past(grp)] == $past(r_ff.serve[r_ff.ptr]))
      else $error("displaced core not made spare");
   phase_seq_a: assert property ((r_ff.st == acsc_pkg::ST_FG && phase_end && // RL12
      r_ff.phase == 2'h0 && !trig_rise) |=> r_ff.phase == 2'h1)
      else $error("gain step did not follow linearity");
   trig_start_a: assert property (trig_rise |=> (r_ff.st == acsc_pkg::ST_FG && !fg_done)) // RL7
      else $error("trigger did not start foreground");
   trim_rd_a: assert property ((reg_rd && reg_addr == acsc_pkg::ADDR_TRIM_LO && !reg_wr) // RL15
      |=> reg_rdata == $past(r_ff.trim[0]))
      else $error("trim read back wrong");

   fg_finish_c: cover property ($rose(fg_done)); // RL17
   bg_swap_c:   cover property (r_ff.st == acsc_pkg::ST_SWAP_MUX ##1 r_ff.st == acsc_pkg::ST_IDLE);
   retrig_c:    cover property (r_ff.st == acsc_pkg::ST_BG_CAL && trig_rise);

endmodule : acsc_ctrl

`default_nettype wire

// file: verilog/acsc_pkg.sv
package acsc_pkg;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h80;
   localparam logic [7:0] ADDR_STATUS   = 8'h81;
   localparam logic [7:0] ADDR_SRC_DLY  = 8'h9A;
   localparam logic [7:0] ADDR_MUX_DLY  = 8'h9B;
   localparam logic [7:0] ADDR_TRIM_LO  = 8'hA0;
   localparam logic [7:0] ADDR_TRIM_HI  = 8'hAF;

   // Control register fields
   localparam int CTRL_BG_EN_BIT   = 0;
   localparam int CTRL_SRC_SEL_BIT = 1;
   localparam int CTRL_SW_TRIG_BIT = 2;

   // Reset values
   localparam logic [2:0] CTRL_RST    = 3'h0;
   localparam logic [7:0] SRC_DLY_RST = 8'h00;
   localparam logic [7:0] MUX_DLY_RST = 8'h00;
   localparam logic [7:0] PHASE_CYC   = 8'h10;

   // Trim array layout: offset per core, gain per core, termination per input
   localparam int TRIM_OFS_BASE  = 0;
   localparam int TRIM_GAIN_BASE = 6;
   localparam int TRIM_TERM_BASE = 12;
   localparam int TRIM_CNT       = 16;

   // Core assignment in foreground mode and the two spares
   localparam logic [2:0] CORE_A  = 3'h0;
   localparam logic [2:0] CORE_B  = 3'h1;
   localparam logic [2:0] CORE_C  = 3'h4;
   localparam logic [2:0] CORE_D  = 3'h5;
   localparam logic [2:0] SPARE_0 = 3'h2;
   localparam logic [2:0] SPARE_1 = 3'h3;
   localparam logic [2:0] LAST_CORE = 3'h5;
   localparam logic [1:0] LAST_PHASE = 2'h2;

   // Sequencer states and calibration steps
   typedef enum logic [2:0] {ST_FG, ST_IDLE, ST_BG_CAL, ST_SWAP_SRC, ST_SWAP_MUX} acsc_state_t;
   typedef enum logic [1:0] {PH_LIN, PH_GAIN, PH_OFS} acsc_phase_t;

endpackage : acsc_pkg
